// *** logic/tsc_conditioning.sv ***
// Temperature readout conditioning with keypad and parameter store
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Two-key press shows flashing 00 prompt
// - Config params need password; then F too
// - Serial below 5000 opens at sensor type
// - Sensor type 0 NTC, 1 PTC; reset or low serial
// - Reset loads sensor type NTC
// - Signed offset added, -19.9 to +19.9
// - Stability 1..15 sets smoothing strength
// - Speed 1..15 caps change per 200ms
// - Blend: ambient minus difference times weight/100
// - Weight 0 ambient, 100 defrost, 50 average
// - Failed defrost probe forces ambient only
// - Unit flag converts setpoint and differential
// - Decimal flag hides tenths when set
// - Timing params apply after power cycle
// - Three direct remote keys (offset, setpoint, differential), scrolling otherwise
module tsc_conditioning
    import tsc_pkg::*;
#(
    parameter int TICK_CLKS = CYCLE_CLKS,
    parameter logic [7:0] PASSWORD = 8'h16
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic signed [15:0] first_probe_raw,
    input wire logic signed [15:0] second_probe_raw,
    input wire logic second_probe_fail,
    input wire tsc_keys_t keys,
    input wire logic reset_proc,
    input wire logic power_restart,
    input wire logic [16:0] serial_num,
    output logic signed [15:0] ctrl_temp,
    output logic signed [15:0] disp_value,
    output logic [3:0] disp_code,
    output logic disp_show_code,
    output logic disp_flash,
    output logic disp_dp,
    output logic cfg_open
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tsc_menu_t menu;
        tsc_params_t prm;
        logic [3:0] stab_act;
        logic [3:0] speed_act;
        logic cfg_ok;
        logic [3:0] idx;
        logic signed [15:0] edit;
        logic [7:0] pw;
        logic [31:0] tick_cnt;
        logic tick;
        logic tick_d;
        logic signed [15:0] temp;
        logic signed [15:0] ctrl;
        logic signed [15:0] dval;
        logic [3:0] dcode;
        logic dshow;
        logic dflash;
        logic ddp;
        logic [31:0] rdata;
    } tsc_st_t;

    localparam tsc_params_t PRM_RST = '{sensor_ptc: 1'b0, cal: DEF_CAL,
        stab: DEF_STAB, speed: DEF_SPEED, blend: DEF_BLEND, unit_f: 1'b0,
        no_dp: 1'b0, setp: DEF_SETP, diff: DEF_DIFF};

    tsc_st_t st_reg;
    tsc_st_t st_next;
    logic signed [15:0] f_amb;
    logic signed [15:0] f_def;
    logic low_serial;
    logic signed [15:0] amb;
    logic signed [15:0] dfr;
    logic signed [15:0] vs;
    logic [3:0] bidx;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [15:0] sat16(input int x);
        if (x > int'(T_MAX)) begin
            return T_MAX;
        end else if (x < int'(T_MIN)) begin
            return T_MIN;
        end
        return 16'(x);
    endfunction : sat16

    function automatic logic signed [15:0] lo(input logic [3:0] i);
        case (i)
            P_CAL: return CAL_MIN;
            P_STAB, P_SPEED: return 16'($signed({1'b0, LIM_TIME_MIN}));
            P_SETP: return SETP_MIN;
            P_DIFF: return DIFF_MIN;
            default: return 16'sh0000;
        endcase
    endfunction : lo

    function automatic logic signed [15:0] hi(input logic [3:0] i);
        case (i)
            P_CAL: return CAL_MAX;
            P_STAB, P_SPEED: return 16'($signed({1'b0, LIM_TIME_MAX}));
            P_BLEND: return 16'($signed({1'b0, BLEND_MAX}));
            P_SETP: return SETP_MAX;
            P_DIFF: return DIFF_MAX;
            default: return 16'sh0001;
        endcase
    endfunction : hi

    function automatic logic signed [15:0] get(input tsc_params_t p,
        input logic [3:0] i);
        case (i)
            P_SENSOR: return 16'($signed({1'b0, p.sensor_ptc}));
            P_CAL: return p.cal;
            P_STAB: return 16'($signed({1'b0, p.stab}));
            P_SPEED: return 16'($signed({1'b0, p.speed}));
            P_BLEND: return 16'($signed({1'b0, p.blend}));
            P_UNIT: return 16'($signed({1'b0, p.unit_f}));
            P_DP: return 16'($signed({1'b0, p.no_dp}));
            P_SETP: return p.setp;
            P_DIFF: return p.diff;
            default: return 16'sh0000;
        endcase
    endfunction : get

    function automatic logic is_cfg(input logic [3:0] i);
        return !(i == P_CAL || i == P_SETP || i == P_DIFF);
    endfunction : is_cfg

    function automatic tsc_params_t put(input tsc_params_t p,
        input logic [3:0] i, input logic signed [15:0] v);
        tsc_params_t q;
        logic signed [15:0] c;
        q = p;
        c = v > hi(i) ? hi(i) : (v < lo(i) ? lo(i) : v);
        case (i)
            P_SENSOR: q.sensor_ptc = c[0];
            P_CAL: q.cal = c;
            P_STAB: q.stab = c[3:0];
            P_SPEED: q.speed = c[3:0];
            P_BLEND: q.blend = c[6:0];
            P_UNIT: begin
                q.unit_f = c[0];
                if (c[0] && !p.unit_f) begin
                    q.setp = sat16(int'(p.setp) * 9 / 5 + F_OFS);
                    q.diff = sat16(int'(p.diff) * 9 / 5);
                end else if (!c[0] && p.unit_f) begin
                    q.setp = sat16((int'(p.setp) - F_OFS) * 5 / 9);
                    q.diff = sat16(int'(p.diff) * 5 / 9);
                end
            end
            P_DP: q.no_dp = c[0];
            P_SETP: q.setp = c;
            P_DIFF: q.diff = c;
            default: q = p;
        endcase
        return q;
    endfunction : put

    // Visible entries depend on access level and reset procedure
    function automatic logic vis(input logic [3:0] i, input logic ok,
        input logic low);
        if (i > P_DIFF) begin
            return 1'b0;
        end else if (i == P_SENSOR) begin
            return reset_proc || (low && ok);
        end
        return ok || !is_cfg(i);
    endfunction : vis

    function automatic logic [3:0] step(input logic [3:0] i,
        input logic up, input logic ok, input logic low);
        logic [3:0] j;
        logic [3:0] r;
        j = i;
        r = i;
        for (int k = 0; k < 9; k++) begin
            j = up ? 4'(j + 4'h1) : 4'(j - 4'h1);
            if (vis(j, ok, low) && r == i) begin
                r = j;
            end
        end
        return r;
    endfunction : step

    // ------------------------------------------------------------
    // Probe filters
    // ------------------------------------------------------------
    tsc_probe_filter u_flt_first (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(st_reg.tick),
        .raw(first_probe_raw),
        .stab(st_reg.stab_act),
        .speed(st_reg.speed_act),
        .temp(f_amb)
    );

    tsc_probe_filter u_flt_second (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(st_reg.tick),
        .raw(second_probe_raw),
        .stab(st_reg.stab_act),
        .speed(st_reg.speed_act),
        .temp(f_def)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        low_serial = serial_num < SERIAL_LIMIT;
        bidx = bus_addr[5:2];

        // Equipment cycle tick
        st_next.tick = 1'b0;
        if (st_reg.tick_cnt >= 32'(TICK_CLKS - 1)) begin
            st_next.tick_cnt = 32'h0000_0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 32'h0000_0001;
        end
        st_next.tick_d = st_reg.tick;

        // Offset and virtual sensor
        amb = sat16(int'(f_amb) + int'(st_reg.prm.cal));
        dfr = sat16(int'(f_def) + int'(st_reg.prm.cal));
        if (second_probe_fail) begin
            vs = amb;
        end else begin
            vs = sat16(int'(amb) - (int'(amb) - int'(dfr))
                * int'(st_reg.prm.blend) / 100);
        end
        if (st_reg.tick_d) begin
            st_next.temp = st_reg.prm.unit_f
                ? sat16(int'(amb) * 9 / 5 + F_OFS) : amb;
            st_next.ctrl = st_reg.prm.unit_f
                ? sat16(int'(vs) * 9 / 5 + F_OFS) : vs;
        end

        // Timing parameters take hold only on restart
        if (power_restart) begin
            st_next.stab_act = st_reg.prm.stab;
            st_next.speed_act = st_reg.prm.speed;
        end

        // Keypad and remote menu
        case (st_reg.menu)
            MN_IDLE: begin
                st_next.cfg_ok = 1'b0;
                if (keys.combo) begin
                    st_next.menu = MN_PROMPT;
                    st_next.pw = 8'h00;
                end else if (keys.remote && !is_cfg(keys.code)) begin
                    st_next.menu = MN_EDIT;
                    st_next.idx = keys.code;
                    st_next.edit = get(st_reg.prm, keys.code);
                end else if (keys.prg) begin
                    st_next.menu = MN_LIST;
                    st_next.idx = reset_proc ? P_SENSOR : P_CAL;
                end
            end
            MN_PROMPT: begin
                if (keys.up && st_reg.pw < PW_MAX) begin
                    st_next.pw = st_reg.pw + 8'h01;
                end else if (keys.down && st_reg.pw != 8'h00) begin
                    st_next.pw = st_reg.pw - 8'h01;
                end else if (keys.sel) begin
                    if (st_reg.pw == PASSWORD) begin
                        st_next.menu = MN_LIST;
                        st_next.cfg_ok = 1'b1;
                        st_next.idx = (low_serial || reset_proc)
                            ? P_SENSOR : P_CAL;
                    end else begin
                        st_next.menu = MN_IDLE;
                    end
                end else if (keys.prg) begin
                    st_next.menu = MN_IDLE;
                end
            end
            MN_LIST: begin
                if (keys.up) begin
                    st_next.idx = step(st_reg.idx, 1'b1, st_reg.cfg_ok,
                        low_serial);
                end else if (keys.down) begin
                    st_next.idx = step(st_reg.idx, 1'b0, st_reg.cfg_ok,
                        low_serial);
                end else if (keys.sel) begin
                    st_next.menu = MN_EDIT;
                    st_next.edit = get(st_reg.prm, st_reg.idx);
                end else if (keys.prg) begin
                    st_next.menu = MN_IDLE;
                end
            end
            MN_EDIT: begin
                if (keys.up && st_reg.edit < hi(st_reg.idx)) begin
                    st_next.edit = st_reg.edit + 16'sh0001;
                end else if (keys.down && st_reg.edit > lo(st_reg.idx)) begin
                    st_next.edit = st_reg.edit - 16'sh0001;
                end else if (keys.sel) begin
                    st_next.menu = MN_LIST;
                    st_next.prm = put(st_reg.prm, st_reg.idx, st_reg.edit);
                end else if (keys.prg) begin
                    st_next.menu = MN_IDLE;
                end
            end
            default: st_next.menu = MN_IDLE;
        endcase

        // Register bus; a bus write follows any keypad commit
        if (bus_wr && bus_addr[1:0] == 2'b00 && bus_addr <= A_PARAM_LAST) begin
            st_next.prm = put(st_next.prm, bidx, bus_wdata[15:0]);
        end
        st_next.rdata = 32'h0000_0000;
        if (bus_rd) begin
            if (bus_addr[1:0] == 2'b00 && bus_addr <= A_PARAM_LAST) begin
                st_next.rdata = 32'(get(st_reg.prm, bidx));
            end else if (bus_addr == A_STATUS) begin
                st_next.rdata = {20'h00000, st_reg.stab_act,
                    st_reg.speed_act, 1'b0, st_reg.cfg_ok, st_reg.menu};
            end else if (bus_addr == A_CTRL) begin
                st_next.rdata = 32'(st_reg.ctrl);
            end else if (bus_addr == A_DISP) begin
                st_next.rdata = 32'(st_reg.dval);
            end
        end

        // Display
        st_next.dflash = st_reg.menu == MN_PROMPT;
        st_next.dshow = st_reg.menu == MN_LIST;
        st_next.dcode = st_reg.idx;
        st_next.ddp = !st_reg.prm.no_dp;
        case (st_reg.menu)
            MN_PROMPT: st_next.dval = 16'($signed({1'b0, st_reg.pw}));
            MN_LIST: st_next.dval = 16'sh0000;
            MN_EDIT: st_next.dval = st_reg.edit;
            default: begin
                if (st_reg.prm.no_dp) begin
                    st_next.dval = st_reg.temp < 0
                        ? 16'((int'(st_reg.temp) - 5) / 10)
                        : 16'((int'(st_reg.temp) + 5) / 10);
                end else begin
                    st_next.dval = st_reg.temp;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.menu <= MN_IDLE;
            st_reg.prm <= PRM_RST;
            st_reg.stab_act <= DEF_STAB;
            st_reg.speed_act <= DEF_SPEED;
            st_reg.ddp <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus_rdata = st_reg.rdata;
    assign ctrl_temp = st_reg.ctrl;
    assign disp_value = st_reg.dval;
    assign disp_code = st_reg.dcode;
    assign disp_show_code = st_reg.dshow;
    assign disp_flash = st_reg.dflash;
    assign disp_dp = st_reg.ddp;
    assign cfg_open = st_reg.cfg_ok;

endmodule : tsc_conditioning
`default_nettype wire

// *** pkg/tsc_pkg.sv ***
// Shared constants and types for the temperature conditioning block
package tsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int CYCLE_MS = 200;
    localparam int CYCLE_CLKS = CYCLE_MS * 1000000 / CLK_NS;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_PARAM_LAST = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_CTRL = 8'h28;
    localparam logic [7:0] A_DISP = 8'h2C;

    // ------------------------------------------------------------
    // Defaults and limits, temperatures in tenths of a degree
    // ------------------------------------------------------------
    localparam logic signed [15:0] T_MAX = 16'sh7FFF;
    localparam logic signed [15:0] T_MIN = 16'sh8000;
    localparam logic signed [15:0] CAL_MAX = 16'sh00C7;
    localparam logic signed [15:0] CAL_MIN = -16'sh00C7;
    localparam logic signed [15:0] DEF_CAL = 16'sh0000;
    localparam logic [3:0] DEF_STAB = 4'h4;
    localparam logic [3:0] DEF_SPEED = 4'h8;
    localparam logic [3:0] LIM_TIME_MIN = 4'h1;
    localparam logic [3:0] LIM_TIME_MAX = 4'hF;
    localparam logic [6:0] DEF_BLEND = 7'h00;
    localparam logic [6:0] BLEND_MAX = 7'h64;
    localparam logic signed [15:0] DEF_SETP = 16'sh0000;
    localparam logic signed [15:0] SETP_MIN = -16'sh0190;
    localparam logic signed [15:0] SETP_MAX = 16'sh0384;
    localparam logic signed [15:0] DEF_DIFF = 16'sh0014;
    localparam logic signed [15:0] DIFF_MIN = 16'sh0001;
    localparam logic signed [15:0] DIFF_MAX = 16'sh00C7;
    localparam int F_OFS = 320;
    localparam logic [16:0] SERIAL_LIMIT = 17'h01388;
    localparam logic [7:0] PW_MAX = 8'h63;
    localparam int FLT_FRAC = 16;
    localparam logic signed [16:0] SLEW_STEP = 17'sh00001;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {P_SENSOR, P_CAL, P_STAB, P_SPEED, P_BLEND,
        P_UNIT, P_DP, P_SETP, P_DIFF} tsc_pidx_t;

    typedef enum logic [1:0] {MN_IDLE, MN_PROMPT, MN_LIST,
        MN_EDIT} tsc_menu_t;

    typedef struct packed {
        logic sensor_ptc;
        logic signed [15:0] cal;
        logic [3:0] stab;
        logic [3:0] speed;
        logic [6:0] blend;
        logic unit_f;
        logic no_dp;
        logic signed [15:0] setp;
        logic signed [15:0] diff;
    } tsc_params_t;

    typedef struct packed {
        logic combo;
        logic up;
        logic down;
        logic sel;
        logic prg;
        logic remote;
        logic [3:0] code;
    } tsc_keys_t;

    typedef struct packed {
        logic primed;
        logic signed [31:0] acc;
        logic signed [15:0] out;
    } tsc_flt_st_t;

endpackage : tsc_pkg

// *** logic/tsc_probe_filter.sv ***
// Per-probe smoothing and per-cycle slew limiting
`timescale 1ns/1ps
`default_nettype none
module tsc_probe_filter
    import tsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire logic signed [15:0] raw,
    input wire logic [3:0] stab,
    input wire logic [3:0] speed,
    output logic signed [15:0] temp
);

    tsc_flt_st_t st_reg;
    tsc_flt_st_t st_next;
    logic signed [31:0] err;
    logic signed [31:0] acc_new;
    logic signed [15:0] tgt;
    logic signed [16:0] d;
    logic signed [16:0] lim;

    always_comb begin
        st_next = st_reg;
        err = (32'(raw) <<< FLT_FRAC) - st_reg.acc;
        // Larger stability shift gives a slower, steadier response
        acc_new = st_reg.acc + (err >>> stab);
        tgt = 16'(acc_new >>> FLT_FRAC);
        d = 17'(tgt) - 17'(st_reg.out);
        lim = $signed({13'h0000, speed}) * SLEW_STEP;
        // Cap the change per equipment cycle
        if (d > lim) begin
            d = lim;
        end else if (d < -lim) begin
            d = -lim;
        end
        if (tick) begin
            if (!st_reg.primed) begin
                // First reading loads directly, no start-up ramp
                st_next.primed = 1'b1;
                st_next.acc = 32'(raw) <<< FLT_FRAC;
                st_next.out = raw;
            end else begin
                st_next.acc = acc_new;
                st_next.out = 16'(17'(st_reg.out) + d);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign temp = st_reg.out;

endmodule : tsc_probe_filter
`default_nettype wire

// *** bench/tsc_assertions.sv ***
// Port assertions for the conditioning block
`timescale 1ns/1ps
`default_nettype none
module tsc_assertions
    import tsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire tsc_keys_t keys,
    input wire logic reset_proc,
    input wire logic [16:0] serial_num,
    input wire logic signed [15:0] ctrl_temp,
    input wire logic signed [15:0] disp_value,
    input wire logic [3:0] disp_code,
    input wire logic disp_show_code,
    input wire logic disp_flash,
    input wire logic cfg_open
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_prompt_zero;
        $rose(disp_flash) |-> disp_value == 0 && !disp_show_code;
    endproperty
    a_prompt_zero: assert property (p_prompt_zero)
        else $error("prompt not showing 00");
    property p_prompt_exit;
        disp_flash && (keys.sel || keys.prg) |-> ##2 !disp_flash;
    endproperty
    a_prompt_exit: assert property (p_prompt_exit)
        else $error("prompt kept after confirm");
    property p_open_from_prompt;
        $rose(cfg_open) |-> $past(disp_flash);
    endproperty
    a_open_from_prompt: assert property (p_open_from_prompt)
        else $error("access without password");
    property p_flash_closed;
        disp_flash |-> !$past(cfg_open);
    endproperty
    a_flash_closed: assert property (p_flash_closed)
        else $error("access open during prompt");
    property p_first_code;
        $rose(cfg_open) |=> disp_show_code && disp_code ==
            ((serial_num < SERIAL_LIMIT || reset_proc) ? 4'h0 : 4'h1);
    endproperty
    a_first_code: assert property (p_first_code)
        else $error("wrong first parameter");
    property p_rd_ctrl;
        bus_rd && bus_addr == A_CTRL |=>
            bus_rdata == {{16{$past(ctrl_temp[15])}}, $past(ctrl_temp)};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control read mismatch");
    property p_rd_disp;
        bus_rd && bus_addr == A_DISP |=>
            bus_rdata == {{16{$past(disp_value[15])}}, $past(disp_value)};
    endproperty
    a_rd_disp: assert property (p_rd_disp)
        else $error("display read mismatch");
    property p_rdata_idle;
        !$past(bus_rd) |-> bus_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
endmodule : tsc_assertions
bind tsc_conditioning tsc_assertions tsc_assertions_i (.clk_sys(clk_sys),
    .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .keys(keys), .reset_proc(reset_proc),
    .serial_num(serial_num), .ctrl_temp(ctrl_temp),
    .disp_value(disp_value), .disp_code(disp_code),
    .disp_show_code(disp_show_code), .disp_flash(disp_flash),
    .cfg_open(cfg_open));
`default_nettype wire

// *** bench/tsc_probe_model.sv ***
// Probe and keypad model facing the conditioning block
`timescale 1ns/1ps
`default_nettype none
module tsc_probe_model
    import tsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic key_go,
    input wire logic [2:0] key_op,
    input wire logic [3:0] key_slot,
    input wire logic signed [15:0] amb,
    input wire logic signed [15:0] dfr,
    input wire logic dfail,
    output tsc_keys_t keys,
    output logic signed [15:0] first_probe_raw,
    output logic signed [15:0] second_probe_raw,
    output logic second_probe_fail
);
    // Keys are single-cycle pulses; a failed probe reads as noise
    always_ff @(posedge clk_sys) begin
        keys <= {key_go ? 6'h20 >> key_op : 6'h00, key_slot};
        first_probe_raw <= amb;
        second_probe_raw <= dfail ? ~second_probe_raw : dfr;
        second_probe_fail <= dfail;
    end
endmodule : tsc_probe_model
`default_nettype wire

// *** bench/tb_temperature_sensor_conditioning.sv ***
// Testbench for the conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb_temperature_sensor_conditioning
    import tsc_pkg::*;
;
    logic clk_sys, rst, bus_wr, bus_rd, go, dfail, reset_proc, power_restart;
    logic sc, fl, dp, cfg, dfail_q;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic [2:0] op;
    logic [3:0] slot, disp_code;
    logic signed [15:0] amb, dfr, p1, p2, ctrl_temp, disp_value;
    logic [16:0] serial_num;
    tsc_keys_t keys;
    int fails, compares;
    logic [31:0] dflt [9] = '{0, 0, 4, 8, 0, 0, 0, 0, 20};
    logic [7:0] ca [5] = '{8'h04, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] cw [5] = '{300, 32'hFFFFFED4, 0, 16, 200};
    logic [31:0] ce [5] = '{199, 32'hFFFFFF39, 1, 15, 100};
    logic [31:0] bl [4] = '{0, 50, 100, 25};
    logic [31:0] be [4] = '{100, 200, 300, 150};

    tsc_conditioning #(.TICK_CLKS(8), .PASSWORD(8'h16)) tsc_conditioning_i (
        .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .first_probe_raw(p1),
        .second_probe_raw(p2), .second_probe_fail(dfail_q), .keys(keys),
        .reset_proc(reset_proc), .power_restart(power_restart),
        .serial_num(serial_num), .ctrl_temp(ctrl_temp),
        .disp_value(disp_value), .disp_code(disp_code),
        .disp_show_code(sc), .disp_flash(fl), .disp_dp(dp),
        .cfg_open(cfg));
    tsc_probe_model tsc_probe_model_i (.clk_sys(clk_sys), .key_go(go),
        .key_op(op), .key_slot(slot), .amb(amb), .dfr(dfr), .dfail(dfail),
        .keys(keys), .first_probe_raw(p1), .second_probe_raw(p2),
        .second_probe_fail(dfail_q));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task results;
        $display("mismatches %0d checks %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        cyc(1);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(n, e, bus_rdata);
        cyc(1);
    endtask : rd
    task key(input logic [2:0] o, input int n);
        repeat (n) begin
            go <= 1'b1;
            op <= o;
            @(posedge clk_sys);
            go <= 1'b0;
            @(posedge clk_sys);
        end
        cyc(3);
    endtask : key
    task pw(input int n);
        key(3'd0, 1);
        key(3'd1, n);
        key(3'd3, 1);
    endtask : pw

    initial begin
        #400000;
        fails++;
        results();
    end

    initial begin
        {rst, bus_wr, bus_rd, go, dfail, reset_proc, power_restart} = 7'h40;
        {bus_addr, bus_wdata, op, slot} = '0;
        amb = 16'sh0064;
        dfr = 16'sh012C;
        serial_num = 17'h01770;
        cyc(3);
        rst <= 1'b0;
        cyc(1);
        chk("dp", 1, {31'h0, dp});
        for (int i = 0; i < 9; i++) rd(8'(4 * i), dflt[i], "dflt");
        wr(8'h30, 5);
        rd(8'h30, 0, "unmapped");
        for (int i = 0; i < 5; i++) begin
            wr(ca[i], cw[i]);
            rd(ca[i], ce[i], "clamp");
        end
        wr(8'h04, 0);
        wr(8'h08, 4);
        wr(8'h0C, 8);
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, bl[i]);
            cyc(30);
            chk("blend", be[i], 32'(ctrl_temp));
            rd(A_CTRL, be[i], "ctrl");
        end
        wr(8'h10, 50);
        wr(8'h04, 15);
        cyc(30);
        chk("cal", 215, 32'(ctrl_temp));
        wr(8'h04, 0);
        dfail <= 1'b1;
        cyc(30);
        chk("fail", 100, 32'(ctrl_temp));
        wr(8'h10, 0);
        chk("tenths", 100, 32'(disp_value));
        wr(8'h18, 1);
        cyc(30);
        chk("whole", 10, 32'(disp_value));
        chk("nodp", 0, {31'h0, dp});
        rd(A_DISP, 10, "disp");
        wr(8'h18, 0);
        wr(8'h1C, 100);
        wr(8'h14, 1);
        cyc(30);
        chk("degf", 500, 32'(ctrl_temp));
        rd(8'h1C, 500, "setp");
        rd(8'h20, 36, "diff");
        wr(8'h14, 0);
        rd(8'h1C, 100, "setp");
        rd(8'h20, 20, "diff");
        wr(8'h08, 1);
        wr(8'h0C, 2);
        rd(A_STATUS, 32'h480, "status");
        power_restart <= 1'b1;
        cyc(1);
        power_restart <= 1'b0;
        rd(A_STATUS, 32'h120, "status");
        amb <= 16'sh00C8;
        cyc(40);
        chk("slew", 1, {31'h0, ctrl_temp > 100 && ctrl_temp <= 110});
        pw(22);
        chk("open", 1, {31'h0, cfg});
        chk("first", 1, {28'h0, disp_code});
        key(3'd3, 1);
        key(3'd1, 3);
        key(3'd3, 1);
        rd(8'h04, 3, "edit");
        key(3'd4, 1);
        pw(5);
        chk("wrongpw", 0, {31'h0, cfg});
        serial_num <= 17'h00FA0;
        pw(22);
        chk("old", 0, {28'h0, disp_code});
        key(3'd4, 1);
        slot <= 4'h1;
        key(3'd5, 1);
        key(3'd1, 1);
        key(3'd3, 1);
        rd(8'h04, 4, "remote");
        key(3'd4, 1);
        reset_proc <= 1'b1;
        key(3'd4, 1);
        chk("rproc", 0, {28'h0, disp_code});
        results();
    end
endmodule : tb_temperature_sensor_conditioning
`default_nettype wire
